// file: hw/watchdog_low_power_debug_regs.sv
// watchdog timer with low power, debug gating and avalon register slave
`timescale 1ns/1ps
// How it works
// - in standby the watchdog keeps counting on the oscillator clock
// - wake interrupt output goes to the low power unit for standby exit
// - wake interrupt output also drives the interrupt expander wake line
// - a watchdog interrupt holds the wake output low for 512 oscillator cycles
// - status bit 2 mirrors the wake output two clocks late
// - in halt the oscillator stops so the tick and pulse timing freeze; bus writes still act
// - debugger suspend of the cpu halts the tick
// - run-free debug mode resumes normal counting
// - real-time single-step keeps the tick halted, interrupts included
// - real-time run-free counts normally
// - mode bit 0 means timeout pulses reset output low 512 cycles
// - clearing mode bit while wake output low resets at once
// - mode bit 1 disables reset output, timeout pulses wake output instead
// - writing 0 to unlock bit does nothing; once cleared stays cleared
// - unlock bit 1 allows disable bit change; writing 1 clears unlock
// - eight bit counter increments once per prescaled tick
// - counter overflow triggers reset or wake interrupt per mode
// - valid key sequence clears the counter
// - counter register shows count in bits 7-0, upper bits zero
// - control registers accept writes only with protected write gate open
// - only 0x55 followed by 0xaa as the next key write clears; any other key value breaks it
// - tick is oscillator divided by 512 then by 1 to 64
module watchdog_low_power_debug_regs #(
  parameter int PULSE_CYCLES = watchdog_pkg::PULSE_OSC_CYCLES,
  parameter int PRE_DIV      = watchdog_pkg::PRE_OSC_DIV
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire watchdog_pkg::av_req_t   av_req,
  output watchdog_pkg::av_rsp_t        av_rsp,
  input  wire watchdog_pkg::cpu_state_t cpu_state,
  input  wire logic                    protected_write_gate,
  output logic                         wake_irq_n,
  output logic                         wake_lpm_n,
  output logic                         wake_irq_line_n,
  output logic                         timeout_reset_out_n
);
  import watchdog_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks on the parameters
  generate
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > (1 << PULSE_W)) begin : g_bad_pulse
      $error("PULSE_CYCLES out of range");
    end
    if (PRE_DIV < 1 || PRE_DIV > (1 << PRE_W)) begin : g_bad_pre
      $error("PRE_DIV out of range");
    end
  endgenerate

  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(PULSE_CYCLES - 1);
  localparam logic [PRE_W-1:0]   PRE_LAST   = PRE_W'(PRE_DIV - 1);

  wd_state_t s_r;
  wd_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // second stage divider limit from the prescale select
  function automatic logic [DIV_W-1:0] div_last(input logic [2:0] ps);
    logic [DIV_W-1:0] v;
    v = '0;
    case (ps)
      3'h0:    v = 6'h00;
      3'h1:    v = 6'h00;
      3'h2:    v = 6'h01;
      3'h3:    v = 6'h03;
      3'h4:    v = 6'h07;
      3'h5:    v = 6'h0f;
      3'h6:    v = 6'h1f;
      3'h7:    v = 6'h3f;
      default: v = 6'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic        req;
  logic        take;
  logic        wr_take;
  logic        wr_lane0;
  logic [7:0]  wbyte;
  logic [15:0] ctrl_view;
  logic [15:0] rd_val;

  // a request stalls one cycle, then is answered
  assign req      = av_req.read | av_req.write;
  assign take     = req & s_r.pend;
  assign wr_take  = take & av_req.write & protected_write_gate;
  assign wr_lane0 = wr_take & av_req.byteenable[0];
  assign wbyte    = av_req.writedata[7:0];

  // control register view, check bits read as zero
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[DISABLE_BIT] = s_r.disable_b;
    ctrl_view[PS_LSB +: 3] = s_r.ps;
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_val = 16'h0000;
    case (av_req.address)
      OFS_SYSTEM_CONTROL_STATUS: begin
        rd_val[STATUS_BIT] = s_r.sts_d2;
        rd_val[MODE_BIT]   = s_r.mode;
        rd_val[UNLOCK_BIT] = s_r.unlock;
      end
      // count in low byte, reserved zero
      OFS_COUNT: rd_val = {8'h00, s_r.cnt};
      OFS_KEY:   rd_val = ctrl_view;
      OFS_CTRL:  rd_val = ctrl_view;
      default:   rd_val = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // tick generation and next state
  logic osc_run;
  logic tick_en;
  logic pre_wrap;
  logic tick;
  logic timeout;
  logic key_clear;
  logic bad_check;
  logic pulse_busy;

  // halt stops the oscillator and everything on it
  assign osc_run = ~cpu_state.halt_mode;
  // debug gating of tick; suspended; rt single step
  // run-free modes leave the tick running; standby not gated
  assign tick_en = osc_run & ~cpu_state.cpu_suspended
                 & ~(cpu_state.rt_mode & cpu_state.rt_single_step);
  // divide by 512 then by prescale
  assign pre_wrap = tick_en & (s_r.pre == PRE_LAST);
  assign tick     = pre_wrap & (s_r.div == div_last(s_r.ps)) & ~s_r.disable_b;
  assign timeout  = tick & (s_r.cnt == 8'hff);
  // second key byte after an arming byte
  assign key_clear = wr_lane0 & (av_req.address == OFS_KEY) & s_r.armed & (wbyte == KEY_FIRE);
  // a wrong check field while enabled forces the timeout action
  assign bad_check = wr_lane0 & (av_req.address == OFS_CTRL)
                   & (wbyte[CHECK_LSB +: 3] != CHECK_GOOD) & ~s_r.disable_b;
  assign pulse_busy = ~s_r.wake_n | ~s_r.rst_o_n;

  always_comb begin
    s_nxt = s_r;
    // bus handshake and read data capture
    s_nxt.pend = req & ~s_r.pend;
    if (req & ~s_r.pend) begin
      s_nxt.rdata = rd_val;
    end

    // prescaler stages
    if (tick_en) begin
      s_nxt.pre = pre_wrap ? '0 : PRE_W'(s_r.pre + 1'b1);
      if (pre_wrap) begin
        s_nxt.div = (s_r.div == div_last(s_r.ps)) ? '0 : DIV_W'(s_r.div + 1'b1);
      end
    end

    // count once per tick, wraps on overflow
    if (tick) begin
      s_nxt.cnt = 8'(s_r.cnt + 1'b1);
    end

    if (wr_lane0 && av_req.address == OFS_KEY) begin
      if (wbyte == KEY_ARM) begin
        s_nxt.armed = 1'b1;
      end else begin
        s_nxt.armed = 1'b0;
      end
    end
    // valid key clears counter, wins over a tick
    if (key_clear) begin
      s_nxt.cnt = 8'h00;
    end

    // control register write
    if (wr_lane0 && av_req.address == OFS_CTRL) begin
      s_nxt.ps = wbyte[PS_LSB +: 3];
      if (s_r.unlock) begin
        s_nxt.disable_b = wbyte[DISABLE_BIT];
      end
    end

    // pulse timing on the oscillator
    if (osc_run && pulse_busy) begin
      if (s_r.pulse_cnt == PULSE_LAST) begin
        s_nxt.wake_n    = 1'b1;
        s_nxt.rst_o_n   = 1'b1;
        s_nxt.pulse_cnt = '0;
      end else begin
        s_nxt.pulse_cnt = PULSE_W'(s_r.pulse_cnt + 1'b1);
      end
    end

    // timeout starts a pulse when none is running
    if ((timeout || bad_check) && !pulse_busy) begin
      s_nxt.pulse_cnt = '0;
      if (s_r.mode) begin
        s_nxt.wake_n = 1'b0;
      end else begin
        s_nxt.rst_o_n = 1'b0;
      end
    end

    // status register write
    if (wr_lane0 && av_req.address == OFS_SYSTEM_CONTROL_STATUS) begin
      s_nxt.mode = wbyte[MODE_BIT];
      // a one clears unlock, a zero does nothing
      if (wbyte[UNLOCK_BIT]) begin
        s_nxt.unlock = 1'b0;
      end
      // leaving interrupt mode during wake pulse resets now
      if (!wbyte[MODE_BIT] && !s_r.wake_n) begin
        s_nxt.wake_n    = 1'b1;
        s_nxt.rst_o_n   = 1'b0;
        s_nxt.pulse_cnt = '0;
      end
    end

    // two clock delay of wake output into status bit
    s_nxt.sts_d1 = s_r.wake_n;
    s_nxt.sts_d2 = s_r.sts_d1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, synchronous reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r.pend      <= 1'b0;
      s_r.rdata     <= 16'h0000;
      s_r.mode      <= RST_MODE;
      s_r.unlock    <= RST_UNLOCK;
      s_r.disable_b <= RST_DISABLE;
      s_r.ps        <= RST_PS;
      s_r.armed     <= 1'b0;
      s_r.cnt       <= 8'h00;
      s_r.pre       <= '0;
      s_r.div       <= '0;
      s_r.pulse_cnt <= '0;
      s_r.wake_n    <= 1'b1;
      s_r.rst_o_n   <= 1'b1;
      s_r.sts_d1    <= 1'b1;
      s_r.sts_d2    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign av_rsp.readdata    = {16'h0000, s_r.rdata};
  assign av_rsp.waitrequest = req & ~s_r.pend;
  assign wake_irq_n         = s_r.wake_n;
  // copy to the low power unit
  assign wake_lpm_n         = s_r.wake_n;
  // copy to the interrupt expander wake line
  assign wake_irq_line_n    = s_r.wake_n;
  assign timeout_reset_out_n = s_r.rst_o_n;

endmodule

// file: hw/watchdog_pkg.sv
// constants, register map and carrier types of the watchdog block
package watchdog_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the avalon slave
  localparam logic [3:0] OFS_SYSTEM_CONTROL_STATUS  = 4'h0; // system_control_status
  localparam logic [3:0] OFS_COUNT = 4'h4; // watchdog_count_value
  localparam logic [3:0] OFS_KEY   = 4'h8; // service_key, reads timer_control
  localparam logic [3:0] OFS_CTRL  = 4'hc; // timer_control

  // field positions
  localparam int UNLOCK_BIT  = 0;  // disable_unlock in system_control_status
  localparam int MODE_BIT    = 1;  // irq_mode_select
  localparam int STATUS_BIT  = 2;  // irq_level_status
  localparam int PS_LSB      = 0;  // prescale select, 3 bits
  localparam int CHECK_LSB   = 3;  // write check, 3 bits
  localparam int DISABLE_BIT = 6;  // timer_disable

  // key and check values
  localparam logic [7:0] KEY_ARM    = 8'h55;
  localparam logic [7:0] KEY_FIRE   = 8'haa;
  localparam logic [2:0] CHECK_GOOD = 3'h5;

  // reset values
  localparam logic       RST_MODE    = 1'b0;
  localparam logic       RST_UNLOCK  = 1'b1;
  localparam logic       RST_DISABLE = 1'b0;
  localparam logic [2:0] RST_PS      = 3'h0;

  // timing, in oscillator cycles (one oscillator cycle per clock)
  localparam int PULSE_OSC_CYCLES = 512;
  localparam int PRE_OSC_DIV      = 512;
  localparam int PULSE_W          = 10;
  localparam int PRE_W            = 9;
  localparam int DIV_W            = 6;

  // avalon request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_t;

  // avalon answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } av_rsp_t;

  // cpu power and debug state
  typedef struct packed {
    logic halt_mode;      // oscillator stopped
    logic cpu_suspended;  // debugger halted the cpu
    logic rt_mode;        // real-time debug mode
    logic rt_single_step; // stepping inside real-time mode
  } cpu_state_t;

  // all state of the watchdog
  typedef struct packed {
    logic               pend;
    logic [15:0]        rdata;
    logic               mode;
    logic               unlock;
    logic               disable_b;
    logic [2:0]         ps;
    logic               armed;
    logic [7:0]         cnt;
    logic [PRE_W-1:0]   pre;
    logic [DIV_W-1:0]   div;
    logic [PULSE_W-1:0] pulse_cnt;
    logic               wake_n;
    logic               rst_o_n;
    logic               sts_d1;
    logic               sts_d2;
  } wd_state_t;

endpackage

// file: sim/test_watchdog_low_power_debug_regs.sv
// self-checking bench of the watchdog block
`timescale 1ns/1ps
module test_watchdog_low_power_debug_regs;
  import watchdog_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  av_req_t av_req = '0;
  av_rsp_t av_rsp;
  cpu_state_t cpu_state = '0;
  logic gate = 1'b0;
  logic wake_irq_n, wake_lpm_n, wake_irq_line_n, timeout_reset_out_n, wake_clear;
  int wake_events, error_cnt = 0, total_checks = 0, seed = 32'h8367;
  logic [31:0] exp_q[$];
  bit kind_q[$];
  watchdog_low_power_debug_regs #(.PULSE_CYCLES(4), .PRE_DIV(4)) u_watchdog_low_power_debug_regs (
    .clock(clock), .rst_n(rst_n), .av_req(av_req), .av_rsp(av_rsp), .cpu_state(cpu_state),
    .protected_write_gate(gate), .wake_irq_n(wake_irq_n), .wake_lpm_n(wake_lpm_n),
    .wake_irq_line_n(wake_irq_line_n), .timeout_reset_out_n(timeout_reset_out_n));
  wake_sink u_wake_sink (.clock(clock), .rst_n(rst_n), .wake_irq_line_n(wake_irq_line_n),
    .wake_lpm_n(wake_lpm_n), .wake_events(wake_events), .wake_clear(wake_clear));
  initial forever #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // compare tasks
  task automatic check_reg(input string what, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic check_flag(input string what, input logic e, input logic s);
    check_reg(what, {31'h0, e}, {31'h0, s});
  endtask
  // avalon cycle; k marks a read that only has to be nonzero
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic g,
                     input logic [15:0] e, input bit k);
    int n;
    n = 0;
    @(posedge clock);
    av_req <= '{read: ~wr, write: wr, address: a, writedata: {24'h00_0000, d}, byteenable: 4'hf};
    gate   <= g;
    if (!wr) begin
      exp_q.push_back({16'h0000, e});
      kind_q.push_back(k);
    end
    do begin
      @(negedge clock);
      n++;
    end while (av_rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      give_verdict();
    end
    @(posedge clock);
    av_req.read  <= 1'b0;
    av_req.write <= 1'b0;
  endtask
  // bounded wait for wake (w=1) or reset out (w=0) to reach a level
  task automatic wait_lvl(input bit w, input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while ((w ? wake_irq_n : timeout_reset_out_n) !== lvl && n < 3000);
    if (n >= 3000) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  // read data monitor against the oldest note
  always @(posedge clock) begin
    if (av_req.read && av_rsp.waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check_flag("note queue", 1'b1, 1'b0);
      else if (kind_q.pop_front()) check_flag("count nonzero", 1'b1, |av_rsp.readdata[15:0] | exp_q.pop_front());
      else check_reg("readdata", exp_q.pop_front(), av_rsp.readdata);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    bus(0, OFS_COUNT, 8'h00, 1, 16'h0000, 0);
    bus(0, OFS_SYSTEM_CONTROL_STATUS, 8'h00, 1, 16'h0005, 0);
    bus(0, OFS_CTRL, 8'h00, 1, 16'h0000, 0);
    bus(0, 4'h2, 8'h00, 1, 16'h0000, 0);
    repeat (20 + ($random(seed) & 15)) @(posedge clock);
    cpu_state <= 4'b0100;
    bus(1, OFS_KEY, KEY_ARM, 1, 0, 0);
    bus(1, OFS_KEY, 8'h3f & $random(seed), 1, 0, 0);
    bus(1, OFS_KEY, KEY_FIRE, 1, 0, 0);
    bus(0, OFS_COUNT, 8'h00, 1, 16'h0000, 1);
    bus(1, OFS_KEY, KEY_ARM, 1, 0, 0);
    bus(1, OFS_KEY, KEY_FIRE, 1, 0, 0);
    bus(0, OFS_COUNT, 8'h00, 1, 16'h0000, 0);
    repeat (100) @(posedge clock);
    bus(0, OFS_COUNT, 8'h00, 1, 16'h0000, 0);
    cpu_state <= 4'b0011;
    repeat (100) @(posedge clock);
    bus(0, OFS_COUNT, 8'h00, 1, 16'h0000, 0);
    cpu_state <= 4'b0010;
    repeat (100) @(posedge clock);
    bus(0, OFS_COUNT, 8'h00, 1, 16'h0000, 1);
    cpu_state <= 4'b0000;
    bus(1, OFS_SYSTEM_CONTROL_STATUS, 8'h00, 1, 0, 0);
    bus(0, OFS_SYSTEM_CONTROL_STATUS, 8'h00, 1, 16'h0005, 0);
    bus(1, OFS_CTRL, 8'h68, 1, 0, 0);
    bus(0, OFS_KEY, 8'h00, 1, 16'h0040, 0);
    bus(1, OFS_CTRL, 8'h28, 1, 0, 0);
    bus(1, OFS_SYSTEM_CONTROL_STATUS, 8'h01, 1, 0, 0);
    bus(1, OFS_CTRL, 8'h68, 1, 0, 0);
    bus(0, OFS_CTRL, 8'h00, 1, 16'h0000, 0);
    bus(1, OFS_SYSTEM_CONTROL_STATUS, 8'h02, 0, 0, 0);
    bus(0, OFS_SYSTEM_CONTROL_STATUS, 8'h00, 1, 16'h0004, 0);
    bus(1, OFS_SYSTEM_CONTROL_STATUS, 8'h02, 1, 0, 0);
    bus(0, OFS_SYSTEM_CONTROL_STATUS, 8'h00, 1, 16'h0006, 0);
    wait_lvl(1, 1'b0);
    @(posedge clock);
    cpu_state <= 4'b1000;
    repeat (10) @(posedge clock);
    cpu_state <= 4'b0000;
    check_flag("reset out", 1'b1, timeout_reset_out_n);
    wait_lvl(1, 1'b1);
    check_flag("wake clear", 1'b1, wake_clear);
    check_flag("one wake event", 1'b1, wake_events == 1);
    // status still shows the old low level inside its two clock lag
    bus(0, OFS_SYSTEM_CONTROL_STATUS, 8'h00, 1, 16'h0002, 0);
    repeat (2) @(posedge clock);
    bus(0, OFS_SYSTEM_CONTROL_STATUS, 8'h00, 1, 16'h0006, 0);
    wait_lvl(1, 1'b0);
    bus(1, OFS_SYSTEM_CONTROL_STATUS, 8'h00, 1, 0, 0);
    // let the reset output settle after the accepting edge
    @(negedge clock);
    check_flag("reset out", 1'b0, timeout_reset_out_n);
    wait_lvl(0, 1'b1);
    wait_lvl(0, 1'b0);
    check_flag("wake quiet", 1'b1, wake_events == 2 && wake_irq_n);
    give_verdict();
  end
endmodule

// file: sim/wake_sink.sv
// interrupt expander and low power unit model on the wake outputs
`timescale 1ns/1ps
module wake_sink (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic wake_irq_line_n,
  input  wire logic wake_lpm_n,
  output int        wake_events,
  output logic      wake_clear
);
  logic line_d_r;
  // edge triggered on the falling wake line
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      line_d_r    <= 1'b1;
      wake_events <= 0;
    end else begin
      line_d_r <= wake_irq_line_n;
      if (line_d_r && !wake_irq_line_n) begin
        wake_events <= wake_events + 1;
      end
    end
  end
  // low power re-entry allowed only with wake high
  assign wake_clear = wake_lpm_n;
endmodule

// file: sim/watchdog_chk.sv
// port assertions of the watchdog block
`timescale 1ns/1ps
module watchdog_chk #(
  parameter int PULSE_CYCLES = 4
) (
  input wire logic                     clock,
  input wire logic                     rst_n,
  input wire watchdog_pkg::av_req_t    av_req,
  input wire watchdog_pkg::av_rsp_t    av_rsp,
  input wire watchdog_pkg::cpu_state_t cpu_state,
  input wire logic                     protected_write_gate,
  input wire logic                     wake_irq_n,
  input wire logic                     wake_lpm_n,
  input wire logic                     wake_irq_line_n,
  input wire logic                     timeout_reset_out_n
);
  import watchdog_pkg::*;
  int   low_cnt_r;
  int   rst_cnt_r;
  int   stab_cnt_r;
  logic wake_d_r;
  logic done;
  logic wr_ok;
  // bus completion and accepted write
  assign done  = (av_req.read | av_req.write) & ~av_rsp.waitrequest;
  assign wr_ok = done & av_req.write & protected_write_gate & av_req.byteenable[0];
  // low-run lengths, halt cycles excluded, and wake stability
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      low_cnt_r  <= 0;
      rst_cnt_r  <= 0;
      stab_cnt_r <= 0;
      wake_d_r   <= 1'b1;
    end else begin
      wake_d_r   <= wake_irq_n;
      low_cnt_r  <= wake_irq_n ? 0 : low_cnt_r + (cpu_state.halt_mode ? 0 : 1);
      rst_cnt_r  <= timeout_reset_out_n ? 0 : rst_cnt_r + (cpu_state.halt_mode ? 0 : 1);
      stab_cnt_r <= (wake_irq_n != wake_d_r) ? 0 : (stab_cnt_r < 15 ? stab_cnt_r + 1 : 15);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // one wake level on all copies
  a_wake_copies: assert property (wake_lpm_n == wake_irq_n && wake_irq_line_n == wake_irq_n)
    else $error("wake copies differ");
  a_wake_width: assert property ($rose(wake_irq_n) && timeout_reset_out_n |-> low_cnt_r == PULSE_CYCLES)
    else $error("wake pulse width wrong");
  a_reset_width: assert property ($rose(timeout_reset_out_n) |-> rst_cnt_r == PULSE_CYCLES)
    else $error("reset pulse width wrong");
  a_one_action: assert property (wake_irq_n || timeout_reset_out_n)
    else $error("wake and reset low together");
  // mode cleared during wake gives reset
  a_mode_clear: assert property (wr_ok && av_req.address == OFS_SYSTEM_CONTROL_STATUS && !av_req.writedata[MODE_BIT]
    && !wake_irq_n |=> !timeout_reset_out_n)
    else $error("no reset after mode clear");
  // status bit follows a settled wake level
  a_status_lag: assert property (done && av_req.read && av_req.address == OFS_SYSTEM_CONTROL_STATUS && stab_cnt_r >= 6
    |-> av_rsp.readdata[STATUS_BIT] == wake_irq_n)
    else $error("status bit wrong");
  a_count_upper: assert property (done && av_req.read && av_req.address == OFS_COUNT
    |-> av_rsp.readdata[31:8] == 24'h00_0000)
    else $error("count upper bits set");
  a_halt_freeze: assert property (cpu_state.halt_mode && !av_req.write
    |=> $stable(wake_irq_n) && $stable(timeout_reset_out_n))
    else $error("outputs moved in halt");
  // one wait cycle per request
  a_wait_one: assert property ((av_req.read || av_req.write) && av_rsp.waitrequest |=> !av_rsp.waitrequest)
    else $error("waitrequest too long");
endmodule
bind watchdog_low_power_debug_regs watchdog_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_watchdog_chk (
  .clock(clock), .rst_n(rst_n), .av_req(av_req), .av_rsp(av_rsp), .cpu_state(cpu_state),
  .protected_write_gate(protected_write_gate), .wake_irq_n(wake_irq_n), .wake_lpm_n(wake_lpm_n),
  .wake_irq_line_n(wake_irq_line_n), .timeout_reset_out_n(timeout_reset_out_n));
